// *** pin_change_pkg.sv ***
package pin_change_pkg;

	// geometry
	localparam int GROUP_COUNT    = 3;
	localparam int PINS_PER_GROUP = 8;
	localparam int PIN_COUNT      = GROUP_COUNT * PINS_PER_GROUP;
	localparam int REG_WIDTH      = 8;
	localparam int DATA_WIDTH     = 32;
	localparam int ADDR_WIDTH     = 12;
	localparam int VECTOR_ID_WIDTH = 2;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FLAGS        = 8'h1B;
	localparam logic [7:0] IDX_MASK_LOW     = 8'h6B;
	localparam logic [7:0] IDX_MASK_MID     = 8'h6C;
	localparam logic [7:0] IDX_MASK_HIGH    = 8'h6D;
	localparam logic [7:0] IDX_GROUP_ENABLE = 8'h68;

	// reset values
	localparam logic [REG_WIDTH-1:0] FLAGS_RESET  = 8'h00;
	localparam logic [REG_WIDTH-1:0] MASK_RESET   = 8'h00;
	localparam logic [REG_WIDTH-1:0] ENABLE_RESET = 8'h00;

	// implemented bits of flag and enable registers
	localparam logic [REG_WIDTH-1:0] GROUP_BITS = 8'h07;

	// field positions in flag and enable registers
	localparam int GROUP0_BIT = 0;
	localparam int GROUP1_BIT = 1;
	localparam int GROUP2_BIT = 2;

	// apb byte lane that carries the register data
	localparam int DATA_LANE = 0;

	typedef enum logic [2:0] {
		SEL_NONE   = 3'h0,
		SEL_FLAGS  = 3'h1,
		SEL_MASK0  = 3'h2,
		SEL_MASK1  = 3'h3,
		SEL_MASK2  = 3'h4,
		SEL_ENABLE = 3'h5
	} reg_sel_t;

	typedef enum logic {
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;

endpackage

// *** pin_change_detect.sv ***
`timescale 1ns/1ns
module pin_change_detect
	import pin_change_pkg::*;
#(
	parameter int WIDTH = PINS_PER_GROUP
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] pins,
	input  wire logic [WIDTH-1:0] mask,
	output logic                  hit
);

	logic [WIDTH-1:0] lastPins_reg;
	logic             primed_reg;

	generate
		if (WIDTH < 1) begin : g_bad
			$error("pin_change_detect: WIDTH must be at least 1");
		end
	endgenerate

	// previous sample of every pin
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lastPins_reg <= '0;
		end else begin
			lastPins_reg <= pins;
		end
	end

	// first sample after reset is a reference, not a change
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			primed_reg <= 1'b0;
		end else begin
			primed_reg <= 1'b1;
		end
	end

	// either edge on an unmasked pin
	assign hit = primed_reg && (|((pins ^ lastPins_reg) & mask));

endmodule

// *** vector_select.sv ***
`timescale 1ns/1ns
module vector_select
	import pin_change_pkg::*;
#(
	parameter int COUNT    = GROUP_COUNT,
	parameter int ID_WIDTH = VECTOR_ID_WIDTH
) (
	input  wire logic                clock,
	input  wire logic                arst_n,
	input  wire logic [COUNT-1:0]    request,
	output logic                     valid,
	output logic [ID_WIDTH-1:0]      id
);

	generate
		if (COUNT > (1 << ID_WIDTH) || COUNT < 1) begin : g_bad
			$error("vector_select: COUNT does not fit ID_WIDTH");
		end
	endgenerate

	// lowest group number has the earliest vector
	function automatic logic [ID_WIDTH-1:0] firstSet(
		input logic [COUNT-1:0] bits
	);
		logic [ID_WIDTH-1:0] result;
		result = '0;
		for (int i = COUNT - 1; i >= 0; i--) begin
			if (bits[i]) begin
				result = ID_WIDTH'(i);
			end
		end
		return result;
	endfunction

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			valid <= 1'b0;
			id    <= '0;
		end else begin
			valid <= |request;
			id    <= firstSet(request);
		end
	end

endmodule

// *** pin_change_interrupt_unit.sv ***
// Notes on behaviour
// - group 2, pins 23..16, enabled by enable bit 2 and global enable.
// - group 1, pins 15..8, enabled by enable bit 1 and global enable.
// - group 0, pins 7..0, enabled by enable bit 0 and global enable.
// - each group requests its own separate vector.
// - change on a group's pin sets its pending flag, bits 2..0.
// - vector requested when flag, group enable and global enable all set.
// - flag clears when the cpu services that group's vector.
// - writing one clears a flag; writing zero leaves it.
// - per-pin mask bit; cleared bit disables change detection on that pin.
// - mask bit 7 is the highest pin of its group, bit 0 lowest.
// - pin changes detected without sleep-dependent clock gating, raising wakeup only for enabled groups.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module pin_change_interrupt_unit
	import pin_change_pkg::*;
#(
	parameter int GROUPS = GROUP_COUNT,
	parameter int WIDTH  = PINS_PER_GROUP
) (
	input  wire logic                    clock,
	input  wire logic                    arst_n,
	// apb side
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [ADDR_WIDTH-1:0]   paddr,
	input  wire logic [DATA_WIDTH-1:0]   pwdata,
	input  wire logic [DATA_WIDTH/8-1:0] pstrb,
	output logic      [DATA_WIDTH-1:0]   prdata,
	output logic                         pready,
	output logic                         pslverr,
	// watched pins
	input  wire logic [PIN_COUNT-1:0]    pins,
	// interrupt dispatch side
	input  wire logic                    globalIntEnable,
	input  wire logic [GROUP_COUNT-1:0]  vectorServiced,
	output logic      [GROUP_COUNT-1:0]  vectorRequest,
	output logic                         vectorValid,
	output logic [VECTOR_ID_WIDTH-1:0]   vectorId,
	output logic                         irq,
	output logic                         wakeup
);

	generate
		if (GROUPS != GROUP_COUNT || WIDTH != PINS_PER_GROUP) begin : g_bad
			$error("pin_change_interrupt_unit: only 3 groups of 8 pins");
		end
		if (PIN_COUNT != GROUPS * WIDTH) begin : g_bad_pins
			$error("pin_change_interrupt_unit: pin count mismatch");
		end
		if (REG_WIDTH != WIDTH) begin : g_bad_width
			$error("pin_change_interrupt_unit: mask must cover a group");
		end
		if (GROUP_COUNT > REG_WIDTH) begin : g_bad_flags
			$error("pin_change_interrupt_unit: flags exceed a register");
		end
		if (GROUP_BITS != REG_WIDTH'((1 << GROUP_COUNT) - 1)) begin : g_bad_bits
			$error("pin_change_interrupt_unit: group bits mismatch");
		end
		if (GROUP2_BIT >= GROUP_COUNT) begin : g_bad_pos
			$error("pin_change_interrupt_unit: field beyond last group");
		end
		if (ADDR_WIDTH != $bits(IDX_FLAGS) + 4) begin : g_bad_addr
			$error("pin_change_interrupt_unit: address width mismatch");
		end
		if (DATA_WIDTH < (DATA_LANE + 1) * REG_WIDTH) begin : g_bad_lane
			$error("pin_change_interrupt_unit: data lane out of range");
		end
		if ((1 << VECTOR_ID_WIDTH) < GROUP_COUNT) begin : g_bad_id
			$error("pin_change_interrupt_unit: vector id too narrow");
		end
		if (IDX_FLAGS == IDX_MASK_LOW || IDX_FLAGS == IDX_MASK_MID ||
			IDX_FLAGS == IDX_MASK_HIGH || IDX_FLAGS == IDX_GROUP_ENABLE ||
			IDX_MASK_LOW == IDX_MASK_MID || IDX_MASK_LOW == IDX_MASK_HIGH ||
			IDX_MASK_LOW == IDX_GROUP_ENABLE ||
			IDX_MASK_MID == IDX_MASK_HIGH ||
			IDX_MASK_MID == IDX_GROUP_ENABLE ||
			IDX_MASK_HIGH == IDX_GROUP_ENABLE) begin : g_bad_map
			$error("pin_change_interrupt_unit: register indices collide");
		end
	endgenerate

	// byte addresses of the registers
	localparam logic [ADDR_WIDTH-1:0] ADDR_FLAGS  = {2'h0, IDX_FLAGS, 2'h0};
	localparam logic [ADDR_WIDTH-1:0] ADDR_MASK0  =
		{2'h0, IDX_MASK_LOW, 2'h0};
	localparam logic [ADDR_WIDTH-1:0] ADDR_MASK1  =
		{2'h0, IDX_MASK_MID, 2'h0};
	localparam logic [ADDR_WIDTH-1:0] ADDR_MASK2  =
		{2'h0, IDX_MASK_HIGH, 2'h0};
	localparam logic [ADDR_WIDTH-1:0] ADDR_ENABLE =
		{2'h0, IDX_GROUP_ENABLE, 2'h0};

	bus_state_t                    busState_reg;
	bus_state_t                    busState_next;
	logic [REG_WIDTH-1:0]          flags_reg;
	logic [REG_WIDTH-1:0]          flags_next;
	logic [REG_WIDTH-1:0]          groupEnable_reg;
	logic [REG_WIDTH-1:0]          maskReg [GROUP_COUNT];
	logic [GROUP_COUNT-1:0]        groupHit;
	logic [GROUP_COUNT-1:0]        activeRequest;
	logic [GROUP_COUNT-1:0]        clearByWrite;
	logic [GROUP_COUNT-1:0]        clearFlag;
	logic [GROUP_COUNT-1:0]        pendingRequest;
	logic                          enabledHit;
	logic [REG_WIDTH-1:0]          writeByte;
	logic [REG_WIDTH-1:0]          readByte;
	reg_sel_t                      accessSel;
	logic                          setupPhase;
	logic                          writeCommit;

	// address decode, shared by read and write paths
	function automatic reg_sel_t decodeAddr(
		input logic [ADDR_WIDTH-1:0] addr
	);
		reg_sel_t sel;
		sel = SEL_NONE;
		unique case (addr)
			ADDR_FLAGS: begin
				sel = SEL_FLAGS;
			end
			ADDR_MASK0: begin
				sel = SEL_MASK0;
			end
			ADDR_MASK1: begin
				sel = SEL_MASK1;
			end
			ADDR_MASK2: begin
				sel = SEL_MASK2;
			end
			ADDR_ENABLE: begin
				sel = SEL_ENABLE;
			end
			default: begin
				sel = SEL_NONE;
			end
		endcase
		return sel;
	endfunction

	assign accessSel   = decodeAddr(paddr);
	assign setupPhase  = psel && !penable;
	assign writeCommit = psel && penable && pready && pwrite &&
		pstrb[DATA_LANE];
	assign writeByte   = pwdata[DATA_LANE*8 +: REG_WIDTH];

	// per-group change detection
	genvar g;
	generate
		for (g = 0; g < GROUP_COUNT; g++) begin : g_group
			pin_change_detect #(
				.WIDTH (PINS_PER_GROUP)
			) u_detect (
				.clock  (clock),
				.arst_n (arst_n),
				.pins   (pins[g*PINS_PER_GROUP +: PINS_PER_GROUP]),
				.mask   (maskReg[g]),
				.hit    (groupHit[g])
			);

			// group request gates: flag, group enable, global enable
			assign activeRequest[g] = flags_reg[g] && groupEnable_reg[g] &&
				globalIntEnable;

			assign clearByWrite[g] = writeCommit &&
				accessSel == SEL_FLAGS && writeByte[g];

			assign clearFlag[g] = vectorServiced[g] ||
				clearByWrite[g];
		end
	endgenerate

	// apb answer state: one cycle after setup the slave is ready
	always_comb begin
		busState_next = BUS_IDLE;
		unique case (busState_reg)
			BUS_IDLE: begin
				busState_next = setupPhase ? BUS_ANSWER : BUS_IDLE;
			end
			BUS_ANSWER: begin
				busState_next = setupPhase ? BUS_ANSWER : BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			busState_reg <= BUS_IDLE;
		end else begin
			busState_reg <= busState_next;
		end
	end

	// ready raised for the access phase that follows each setup
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= setupPhase;
		end
	end

	// unmapped or misaligned address answers with an error
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pslverr <= 1'b0;
		end else if (setupPhase) begin
			pslverr <= accessSel == SEL_NONE;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// read mux
	always_comb begin
		readByte = '0;
		unique case (accessSel)
			SEL_FLAGS: begin
				readByte = flags_reg & GROUP_BITS;
			end
			SEL_MASK0: begin
				readByte = maskReg[GROUP0_BIT];
			end
			SEL_MASK1: begin
				readByte = maskReg[GROUP1_BIT];
			end
			SEL_MASK2: begin
				readByte = maskReg[GROUP2_BIT];
			end
			SEL_ENABLE: begin
				readByte = groupEnable_reg & GROUP_BITS;
			end
			SEL_NONE: begin
				readByte = '0;
			end
		endcase
	end

	// read data captured in setup, stable through the access phase
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= '0;
		end else if (setupPhase && !pwrite) begin
			prdata <= {{(DATA_WIDTH-REG_WIDTH){1'b0}}, readByte};
		end
	end

	// mask registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < GROUP_COUNT; i++) begin
				maskReg[i] <= MASK_RESET;
			end
		end else if (writeCommit) begin
			if (accessSel == SEL_MASK0) begin
				maskReg[GROUP0_BIT] <= writeByte;
			end
			if (accessSel == SEL_MASK1) begin
				maskReg[GROUP1_BIT] <= writeByte;
			end
			if (accessSel == SEL_MASK2) begin
				maskReg[GROUP2_BIT] <= writeByte;
			end
		end
	end

	// group enable register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			groupEnable_reg <= ENABLE_RESET;
		end else if (writeCommit && accessSel == SEL_ENABLE) begin
			groupEnable_reg <= writeByte & GROUP_BITS;
		end
	end

	// pending flags: a new change wins over any clear in the same cycle
	always_comb begin
		flags_next = flags_reg;
		for (int i = 0; i < GROUP_COUNT; i++) begin
			if (clearFlag[i]) begin
				flags_next[i] = 1'b0;
			end
			if (groupHit[i]) begin
				flags_next[i] = 1'b1;
			end
		end
		flags_next = flags_next & GROUP_BITS;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flags_reg <= FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// requests not already being entered by the cpu
	assign pendingRequest = activeRequest & ~vectorServiced;

	// per-group vector requests
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			vectorRequest <= '0;
		end else begin
			vectorRequest <= pendingRequest;
		end
	end

	// summary interrupt line
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |pendingRequest;
		end
	end

	// change on an unmasked pin of an enabled group
	assign enabledHit = globalIntEnable &&
		|(groupHit & groupEnable_reg[GROUP_COUNT-1:0]);

	// wake from sleep on any enabled group change
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wakeup <= 1'b0;
		end else begin
			wakeup <= enabledHit;
		end
	end

	// highest-priority vector number for the dispatcher
	vector_select #(
		.COUNT    (GROUP_COUNT),
		.ID_WIDTH (VECTOR_ID_WIDTH)
	) u_select (
		.clock   (clock),
		.arst_n  (arst_n),
		.request (pendingRequest),
		.valid   (vectorValid),
		.id      (vectorId)
	);

endmodule

// *** pin_change_assertions.sv ***
`timescale 1ns/1ns
module pin_change_assertions (
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        globalIntEnable,
	input wire logic [2:0]  vectorServiced,
	input wire logic [2:0]  vectorRequest,
	input wire logic        vectorValid,
	input wire logic        irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	property p_irq;
		irq == |vectorRequest;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not or of requests");
	property p_global;
		|vectorRequest |-> $past(globalIntEnable);
	endproperty
	a_global: assert property (p_global) else $error("request w/o global");
	property p_valid;
		|vectorRequest |-> ##[0:1] vectorValid;
	endproperty
	a_valid: assert property (p_valid) else $error("no vector valid");
	property p_service;
		|(vectorServiced & vectorRequest)
			|=> (vectorRequest & $past(vectorServiced)) == 3'h0;
	endproperty
	a_service: assert property (p_service) else $error("request kept");
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_ready_one;
		pready |=> !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("long ready");
	property p_unmapped;
		psel && !penable
			&& !(paddr inside {12'h06C, 12'h1A0, 12'h1AC, 12'h1B0, 12'h1B4})
			|=> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no slverr");
	property p_upper;
		pready |-> prdata[31:8] == 24'h0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper data set");
endmodule
bind pin_change_interrupt_unit pin_change_assertions u_chk (
	.clock(clock),
	.arst_n(arst_n),
	.psel(psel),
	.penable(penable),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.globalIntEnable(globalIntEnable),
	.vectorServiced(vectorServiced),
	.vectorRequest(vectorRequest),
	.vectorValid(vectorValid),
	.irq(irq)
);

// *** cpu_dispatch_model.sv ***
`timescale 1ns/1ns
module cpu_dispatch_model
	import pin_change_pkg::*;
#(
	parameter int HOLDOFF = 6
) (
	input  wire logic                       clock,
	input  wire logic                       arst_n,
	input  wire logic                       serve,
	input  wire logic                       vectorValid,
	input  wire logic [VECTOR_ID_WIDTH-1:0] vectorId,
	output logic      [GROUP_COUNT-1:0]     vectorServiced
);
	int cnt;
	// enters one routine, then waits before taking the next vector
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 0;
			vectorServiced <= '0;
		end else begin
			vectorServiced <= '0;
			if (cnt != 0) begin
				cnt <= cnt - 1;
			end else if (serve && vectorValid) begin
				vectorServiced <= GROUP_COUNT'(1) << vectorId;
				cnt <= HOLDOFF;
			end
		end
	end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench
	import pin_change_pkg::*;
;
	logic        clock;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [23:0] pins;
	logic        globalIntEnable;
	logic        serve;
	logic [2:0]  vectorServiced;
	logic [2:0]  vectorRequest;
	logic        vectorValid;
	logic [1:0]  vectorId;
	logic        irq;
	logic        wakeup;
	logic [31:0] rdata;
	logic        err;
	int          bad_count;
	int          compares;
	logic [7:0]  regs [5];

	pin_change_interrupt_unit u_dut (
		.clock(clock),
		.arst_n(arst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.pins(pins),
		.globalIntEnable(globalIntEnable),
		.vectorServiced(vectorServiced),
		.vectorRequest(vectorRequest),
		.vectorValid(vectorValid),
		.vectorId(vectorId),
		.irq(irq),
		.wakeup(wakeup)
	);
	cpu_dispatch_model u_cpu (
		.clock(clock),
		.arst_n(arst_n),
		.serve(serve),
		.vectorValid(vectorValid),
		.vectorId(vectorId),
		.vectorServiced(vectorServiced)
	);

	task wrap_up;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// one apb transfer, index turned into byte address
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			wrap_up;
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rdata, exp);
	endtask
	task flip(input int p);
		@(posedge clock);
		pins <= pins ^ (24'h1 << p);
		tick(3);
	endtask

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		#100000;
		bad_count++;
		wrap_up;
	end
	initial begin
		regs = '{IDX_FLAGS, IDX_MASK_LOW, IDX_MASK_MID, IDX_MASK_HIGH,
			IDX_GROUP_ENABLE};
		{arst_n, psel, penable, pwrite, globalIntEnable, serve} = '0;
		{paddr, pwdata, pins} = '0;
		pstrb = 4'hF;
		bad_count = 0;
		compares = 0;
		tick(3);
		arst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(regs[i], 32'h0);
		end
		apb(1'b1, IDX_FLAGS, 32'hFF);
		rd(IDX_FLAGS, 32'h0);
		apb(1'b1, IDX_GROUP_ENABLE, 32'hFF);
		rd(IDX_GROUP_ENABLE, 32'(GROUP_BITS));
		apb(1'b1, IDX_GROUP_ENABLE, 32'h0);
		for (int g = 1; g < 4; g++) begin
			apb(1'b1, regs[g], 32'h59 + g);
			rd(regs[g], 32'h59 + g);
		end
		apb(1'b0, 8'h00, 32'h0);
		chk(32'(err), 32'h1);
		chk(rdata, 32'h0);
		$display("test registers done");
		for (int g = 0; g < 3; g++) begin
			apb(1'b1, regs[g + 1], 32'h80);
			flip(8 * g + 6);
			rd(IDX_FLAGS, 32'h0);
			flip(8 * g + 7);
			rd(IDX_FLAGS, 32'h1 << g);
			chk(32'(vectorRequest), 32'h0);
			apb(1'b1, IDX_FLAGS, 32'h0);
			rd(IDX_FLAGS, 32'h1 << g);
			apb(1'b1, IDX_FLAGS, 32'h1 << g);
			rd(IDX_FLAGS, 32'h0);
			flip(8 * g + 7);
			apb(1'b1, IDX_GROUP_ENABLE, 32'h1 << g);
			globalIntEnable <= 1'b1;
			tick(3);
			chk(32'(vectorRequest), 32'h1 << g);
			chk(32'(irq), 32'h1);
			chk(32'(vectorId), 32'(g));
			chk(32'(vectorValid), 32'h1);
			globalIntEnable <= 1'b0;
			tick(2);
			chk(32'(vectorRequest), 32'h0);
			globalIntEnable <= 1'b1;
			serve <= 1'b1;
			tick(8);
			serve <= 1'b0;
			rd(IDX_FLAGS, 32'h0);
			chk(32'(irq), 32'h0);
			apb(1'b1, regs[g + 1], 32'h0);
			globalIntEnable <= 1'b0;
			$display("test group %0d done", g);
		end
		apb(1'b1, IDX_MASK_MID, 32'h01);
		apb(1'b1, IDX_MASK_HIGH, 32'h01);
		apb(1'b1, IDX_GROUP_ENABLE, 32'h7);
		globalIntEnable <= 1'b1;
		@(posedge clock);
		pins <= pins ^ 24'h010000;
		tick(2);
		chk(32'(wakeup), 32'h1);
		tick(1);
		chk(32'(wakeup), 32'h0);
		flip(8);
		chk(32'(vectorRequest), 32'h6);
		chk(32'(vectorId), 32'h1);
		serve <= 1'b1;
		tick(20);
		rd(IDX_FLAGS, 32'h0);
		$display("test priority done");
		wrap_up;
	end
endmodule
